// [src/cgcr_regs.v]
`timescale 1ns/10ps
`include "cgcr_defines.vh"

module cgcr_regs (
  input  wire        i_core_clk,     // Core clock
  input  wire        i_reset,        // Sync reset, high
  input  wire [7:0]  i_addr,         // Register byte address
  input  wire        i_wr,           // Write strobe
  input  wire        i_rd,           // Read strobe
  input  wire [15:0] i_wdata,        // Write data
  output reg  [15:0] o_rdata,        // Read data
  input  wire        i_ee_din,       // Data pin input level
  output reg         o_ee_dout,      // Data pin output
  output reg         o_ee_doe,       // Data pin output enable
  output reg         o_ee_sk,        // Serial clock pin
  output reg         o_ee_cs,        // Chip select pin
  input  wire        i_tx_bist_done, // TX memory test done
  input  wire        i_tx_bist_fail, // TX memory test failed
  input  wire [2:0]  i_tx_bist_cnt,  // TX failure count
  input  wire        i_rx_bist_done, // RX memory test done
  input  wire        i_rx_bist_fail, // RX memory test failed
  input  wire [2:0]  i_rx_bist_cnt,  // RX failure count
  output reg         o_bist_start,   // Start memory tests
  output reg  [15:0] o_mac_low,      // Low MAC word
  output reg  [15:0] o_mac_mid,      // Middle MAC word
  output reg  [15:0] o_mac_high,     // High MAC word
  output reg         o_drive_16ma,   // Pad drive strength
  output reg         o_clk_src_sel,  // Bus clock source
  output reg  [1:0]  o_clk_div,      // Bus clock divider
  output reg         o_qm_reset,     // Queue manager reset
  output reg         o_global_reset  // Core global reset
);
  // ****************************************************
  // Loader state machine (one-hot)
  // ****************************************************
  localparam [4:0] ST_STRAP = 5'b00001;
  localparam [4:0] ST_LOW   = 5'b00010;
  localparam [4:0] ST_MID   = 5'b00100;
  localparam [4:0] ST_HIGH  = 5'b01000;
  localparam [4:0] ST_IDLE  = 5'b10000;

  reg [4:0]  state_r;
  reg [4:0]  state_nxt;
  reg        ee_present_r;
  reg [15:0] bcc_r;
  reg [5:0]  eec_r;
  reg [1:0]  grr_r;
  reg        ld_start_r;
  reg [5:0]  ld_addr_r;
  wire       ld_cs;
  wire       ld_sk;
  wire       ld_dout;
  wire       ld_busy;
  wire       ld_done;
  wire [15:0] ld_word;
  wire       soft_rst;
  wire       sw_en;
  reg        ld_sk_d_r;
  reg [4:0]  ld_rise_r;

  // Decode shared by the register and soft reset write paths
  function hit;
    input [7:0] a;
    input [7:0] off;
    begin
      hit = (a == off);
    end
  endfunction

  assign soft_rst = i_reset | grr_r[`CGCR_RST_GLB_BIT];
  assign sw_en    = eec_r[`CGCR_EE_SW_EN_BIT];

  // ****************************************************
  // Serial word reader
  // ****************************************************
  cgcr_ee_loader u_loader (
    .i_core_clk (i_core_clk),
    .i_reset    (soft_rst),
    .i_start    (ld_start_r),
    .i_addr     (ld_addr_r),
    .i_din      (i_ee_din),
    .o_cs       (ld_cs),
    .o_sk       (ld_sk),
    .o_dout     (ld_dout),
    .o_busy     (ld_busy),
    .o_done     (ld_done),
    .o_word     (ld_word)
  );

  // Count loader clock rises so the data pin is released after
  // the command; avoids fighting the EEPROM in the data phase
  always @(posedge i_core_clk) begin
    if (soft_rst) begin
      ld_sk_d_r <= 1'b0;
      ld_rise_r <= 5'h00;
    end else begin
      ld_sk_d_r <= ld_sk;
      if (ld_start_r)
        ld_rise_r <= 5'h00;
      else if (ld_sk && !ld_sk_d_r && ld_rise_r != 5'h1f)
        ld_rise_r <= ld_rise_r + 5'h01;
    end
  end

  // Next loader state; strap is sampled once, after release
  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_STRAP: state_nxt = i_ee_din ? ST_LOW : ST_IDLE;
      ST_LOW:   if (ld_done) state_nxt = ST_MID;
      ST_MID:   if (ld_done) state_nxt = ST_HIGH;
      ST_HIGH:  if (ld_done) state_nxt = ST_IDLE;
      ST_IDLE:  state_nxt = ST_IDLE;
      default:  state_nxt = ST_IDLE;
    endcase
  end

  // Loader sequencing, kicks one word read per state
  always @(posedge i_core_clk) begin
    if (soft_rst) begin
      state_r      <= ST_STRAP;
      ee_present_r <= 1'b0;
      ld_start_r   <= 1'b0;
      ld_addr_r    <= `CGCR_EE_WORD_LOW;
      o_bist_start <= 1'b0;
    end else begin
      state_r      <= state_nxt;
      o_bist_start <= (state_r == ST_STRAP);
      if (state_r == ST_STRAP)
        ee_present_r <= i_ee_din;
      // Loader issues only reads; only the software pin mode can alter EEPROM content
      ld_start_r <= 1'b0;
      if (state_nxt == ST_LOW && state_r == ST_STRAP) begin
        ld_start_r <= 1'b1;
        ld_addr_r  <= `CGCR_EE_WORD_LOW;
      end else if (ld_done && state_r == ST_LOW) begin
        ld_start_r <= 1'b1;
        ld_addr_r  <= `CGCR_EE_WORD_MID;
      end else if (ld_done && state_r == ST_MID) begin
        ld_start_r <= 1'b1;
        ld_addr_r  <= `CGCR_EE_WORD_HIGH;
      end
    end
  end

  // ****************************************************
  // Register writes; host write wins over a late load
  // ****************************************************
  always @(posedge i_core_clk) begin
    if (soft_rst) begin
      o_mac_low  <= `CGCR_RST_MAC_WORD;
      o_mac_mid  <= `CGCR_RST_MAC_WORD;
      o_mac_high <= `CGCR_RST_MAC_WORD;
      bcc_r      <= `CGCR_RST_BUS_CLK;
      eec_r      <= `CGCR_RST_EE_CTRL;
    end else begin
      if (ld_done && state_r == ST_LOW)
        o_mac_low <= ld_word;
      if (ld_done && state_r == ST_MID)
        o_mac_mid <= ld_word;
      if (ld_done && state_r == ST_HIGH)
        o_mac_high <= ld_word;
      if (i_wr && hit(i_addr, `CGCR_OFF_MAC_MID))
        o_mac_mid <= i_wdata;
      if (i_wr && hit(i_addr, `CGCR_OFF_MAC_HIGH))
        o_mac_high <= i_wdata;
      // Source bit 2 is reserved, so it is held at 0
      if (i_wr && hit(i_addr, `CGCR_OFF_BUS_CLK))
        bcc_r <= i_wdata & `CGCR_BCC_WR_MASK;
      if (i_wr && hit(i_addr, `CGCR_OFF_EE_PIN))
        eec_r <= i_wdata[5:0];
    end
  end

  // Soft reset bits: hardware reset or a host write of 0 clears them, soft reset does not
  always @(posedge i_core_clk) begin
    if (i_reset)
      grr_r <= 2'b00;
    else if (i_wr && hit(i_addr, `CGCR_OFF_SOFT_RST))
      grr_r <= i_wdata[1:0];
  end

  // ****************************************************
  // Control outputs and pin ownership
  // ****************************************************
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_drive_16ma   <= 1'b0;
      o_clk_src_sel  <= 1'b0;
      o_clk_div      <= 2'b00;
      o_qm_reset     <= 1'b0;
      o_global_reset <= 1'b0;
      o_ee_dout      <= 1'b0;
      o_ee_doe       <= 1'b0;
      o_ee_sk        <= 1'b0;
      o_ee_cs        <= 1'b0;
    end else begin
      o_drive_16ma   <= bcc_r[`CGCR_BCC_DRIVE_BIT];
      o_clk_src_sel  <= bcc_r[`CGCR_BCC_SRC_BIT];
      o_clk_div      <= bcc_r[1:0];
      o_qm_reset     <= grr_r[`CGCR_RST_QM_BIT];
      o_global_reset <= grr_r[`CGCR_RST_GLB_BIT];
      if (sw_en) begin
        o_ee_dout <= eec_r[`CGCR_EE_DOUT_BIT];
        o_ee_doe  <= eec_r[`CGCR_EE_DIR_BIT];
        o_ee_sk   <= eec_r[`CGCR_EE_CLK_BIT];
        o_ee_cs   <= eec_r[`CGCR_EE_CS_BIT];
      end else begin
        // Drive data only in command phase of a load
        o_ee_dout <= ld_dout;
        o_ee_doe  <= ld_busy & ld_cs &
                     (ld_rise_r < 5'd9);
        o_ee_sk   <= ld_sk;
        o_ee_cs   <= ld_cs;
      end
    end
  end

  // ****************************************************
  // Read data, registered; unmapped reads return zero
  // ****************************************************
  always @(posedge i_core_clk) begin
    if (i_reset) begin
      o_rdata <= 16'h0000;
    end else if (i_rd) begin
      case (i_addr)
        `CGCR_OFF_MAC_MID:  o_rdata <= o_mac_mid;
        `CGCR_OFF_MAC_HIGH: o_rdata <= o_mac_high;
        `CGCR_OFF_BUS_CLK:  o_rdata <= bcc_r;
        // Direction bit is write-only and reads zero
        `CGCR_OFF_EE_PIN:
          o_rdata <= {10'h000, 1'b0, eec_r[4], i_ee_din,
                      eec_r[2:0]};
        `CGCR_OFF_SELFTEST:
          o_rdata <= {3'h0, i_tx_bist_done, i_tx_bist_fail,
                      i_tx_bist_cnt, 3'h0, i_rx_bist_done,
                      i_rx_bist_fail, i_rx_bist_cnt};
        `CGCR_OFF_SOFT_RST: o_rdata <= {14'h0000, grr_r};
        default:            o_rdata <= 16'h0000;
      endcase
    end
  end
endmodule

// [include/cgcr_defines.vh]
`ifndef CGCR_DEFINES_VH
`define CGCR_DEFINES_VH

// ******************************************************
// Register offsets (byte addresses of 16-bit words)
// ******************************************************
`define CGCR_OFF_MAC_MID      8'h12
`define CGCR_OFF_MAC_HIGH     8'h14
`define CGCR_OFF_BUS_CLK      8'h20
`define CGCR_OFF_EE_PIN       8'h22
`define CGCR_OFF_SELFTEST     8'h24
`define CGCR_OFF_SOFT_RST     8'h26

// ******************************************************
// Field positions
// ******************************************************
`define CGCR_BCC_DRIVE_BIT    6
`define CGCR_BCC_SRC_BIT      2
`define CGCR_EE_DIR_BIT       5
`define CGCR_EE_SW_EN_BIT     4
`define CGCR_EE_DIN_BIT       3
`define CGCR_EE_DOUT_BIT      2
`define CGCR_EE_CLK_BIT       1
`define CGCR_EE_CS_BIT        0
`define CGCR_RST_QM_BIT       1
`define CGCR_RST_GLB_BIT      0

// ******************************************************
// Reset values and write mask
// ******************************************************
`define CGCR_RST_MAC_WORD     16'h0000
`define CGCR_RST_BUS_CLK      16'h0000
`define CGCR_RST_EE_CTRL      6'h00
`define CGCR_BCC_WR_MASK      16'hFFFB

// ******************************************************
// EEPROM loader constants
// ******************************************************
`define CGCR_EE_WORD_LOW      6'h01
`define CGCR_EE_WORD_MID      6'h02
`define CGCR_EE_WORD_HIGH     6'h03
`define CGCR_EE_READ_OP       3'b110
`define CGCR_EE_SK_HALF_NS    1000
`define CGCR_CLK_PERIOD_NS    40
// 1000 ns half period over a 40 ns clock, sized for the 8-bit timer
`define CGCR_EE_SK_HALF_CYC   8'h19

`endif

// [src/cgcr_ee_loader.v]
`timescale 1ns/10ps
`include "cgcr_defines.vh"

// ******************************************************
// Serial EEPROM word reader (3-wire, 6-bit address)
// ******************************************************
module cgcr_ee_loader (
  input  wire        i_core_clk,   // Core clock
  input  wire        i_reset,      // Sync reset, high
  input  wire        i_start,      // Start one word read
  input  wire [5:0]  i_addr,       // Word address
  input  wire        i_din,        // Serial data from EEPROM
  output reg         o_cs,         // Chip select
  output reg         o_sk,         // Serial clock
  output reg         o_dout,       // Serial data to EEPROM
  output reg         o_busy,       // Read in progress
  output reg         o_done,       // Word valid pulse
  output reg  [15:0] o_word        // Word read
);
  localparam [7:0] HALF = `CGCR_EE_SK_HALF_CYC;
  reg [7:0]  tmr_r;
  reg [4:0]  bit_r;
  reg [8:0]  cmd_r;
  wire [8:0] cmd_w;

  assign cmd_w = {`CGCR_EE_READ_OP, i_addr};

  // Each bit: SK low half then SK high half; sample on rising
  // Data out changes only after a falling clock, never at a rise
  // 9 command bits then 16 data bits, MSB first
  always @(posedge i_core_clk) begin
    o_done <= 1'b0;
    if (i_reset) begin
      o_cs   <= 1'b0;
      o_sk   <= 1'b0;
      o_dout <= 1'b0;
      o_busy <= 1'b0;
      o_word <= 16'h0000;
      tmr_r  <= 8'h00;
      bit_r  <= 5'h00;
      cmd_r  <= 9'h000;
    end else if (!o_busy) begin
      if (i_start) begin
        o_busy <= 1'b1;
        o_cs   <= 1'b1;
        o_dout <= cmd_w[8];
        cmd_r  <= {cmd_w[7:0], 1'b0};
        bit_r  <= 5'h00;
        tmr_r  <= 8'h00;
      end
    end else if (tmr_r != HALF - 8'h01) begin
      tmr_r <= tmr_r + 8'h01;
    end else begin
      tmr_r <= 8'h00;
      o_sk  <= ~o_sk;
      if (!o_sk) begin
        if (bit_r >= 5'd9)
          o_word <= {o_word[14:0], i_din};
      end else begin
        cmd_r <= {cmd_r[7:0], 1'b0};
        if (bit_r < 5'd8)
          o_dout <= cmd_r[8];
        else
          o_dout <= 1'b0;
        if (bit_r == 5'd24) begin
          o_busy <= 1'b0;
          o_cs   <= 1'b0;
          o_done <= 1'b1;
          o_dout <= 1'b0;
        end
        bit_r <= bit_r + 5'h01;
      end
    end
  end
endmodule

// [testbench/cgcr_regs_checker.sv]
`timescale 1ns/10ps
`include "cgcr_defines.vh"
// ****
// Port checker for the register bank
// ****
module cgcr_regs_checker (
  input wire logic        i_core_clk,     // Clock
  input wire logic        i_reset,        // Sync reset
  input wire logic [7:0]  i_addr,         // Address
  input wire logic        i_wr,           // Write strobe
  input wire logic        i_rd,           // Read strobe
  input wire logic [15:0] i_wdata,        // Write data
  input wire logic [15:0] o_rdata,        // Read data
  input wire logic        i_ee_din,       // Data pin level
  input wire logic        o_ee_sk,        // Serial clock
  input wire logic        o_ee_doe,       // Data enable
  input wire logic        i_tx_bist_done, // TX done
  input wire logic        i_tx_bist_fail, // TX fail
  input wire logic [2:0]  i_tx_bist_cnt,  // TX count
  input wire logic        i_rx_bist_done, // RX done
  input wire logic        i_rx_bist_fail, // RX fail
  input wire logic [2:0]  i_rx_bist_cnt,  // RX count
  input wire logic        o_bist_start,   // Test kick
  input wire logic [15:0] o_mac_mid,      // MAC middle
  input wire logic [15:0] o_mac_high,     // MAC high
  input wire logic        o_drive_16ma,   // Pad drive
  input wire logic        o_clk_src_sel,  // Clock source
  input wire logic [1:0]  o_clk_div,      // Divider
  input wire logic        o_qm_reset,     // Queue reset
  input wire logic        o_global_reset  // Global reset
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // Host accesses, reads only when no write shares the cycle
  sequence s_rd(logic [7:0] a);
    i_rd && !i_wr && i_addr == a;
  endsequence
  sequence s_wr(logic [7:0] a);
    i_wr && i_addr == a;
  endsequence
  // Control outputs land two edges after the write edge
  chk_mid_read: assert property (s_rd(`CGCR_OFF_MAC_MID) |=>
    o_rdata == $past(o_mac_mid)) else $error("mid word read wrong");
  chk_high_write: assert property (s_wr(`CGCR_OFF_MAC_HIGH) |=>
    o_mac_high == $past(i_wdata)) else $error("high word not written");
  chk_drive_sel: assert property (s_wr(`CGCR_OFF_BUS_CLK) |->
    ##2 o_drive_16ma == $past(i_wdata[6], 2)) else $error("drive wrong");
  chk_src_zero: assert property (o_clk_src_sel == 1'b0)
    else $error("clock source left 125 MHz");
  chk_div_field: assert property (s_wr(`CGCR_OFF_BUS_CLK) |->
    ##2 o_clk_div == $past(i_wdata[1:0], 2)) else $error("divider wrong");
  chk_sw_pins: assert property (s_wr(`CGCR_OFF_EE_PIN) ##0 i_wdata[4] |->
    ##2 o_ee_sk == $past(i_wdata[1], 2) &&
    o_ee_doe == $past(i_wdata[5], 2)) else $error("pins not driven");
  chk_din_live: assert property (s_rd(`CGCR_OFF_EE_PIN) |=>
    o_rdata[3] == $past(i_ee_din) && !o_rdata[5]) else $error("pin read");
  chk_bist_read: assert property (s_rd(`CGCR_OFF_SELFTEST) |=> o_rdata ==
    {3'b000, $past(i_tx_bist_done), $past(i_tx_bist_fail),
    $past(i_tx_bist_cnt), 3'b000, $past(i_rx_bist_done),
    $past(i_rx_bist_fail), $past(i_rx_bist_cnt)}) else $error("bist read");
  chk_soft_bits: assert property (s_wr(`CGCR_OFF_SOFT_RST) |-> ##2
    o_qm_reset == $past(i_wdata[1], 2) &&
    o_global_reset == $past(i_wdata[0], 2)) else $error("soft reset");
  chk_bist_kick: assert property ($fell(i_reset) |->
    ##[0:2] o_bist_start) else $error("self test not started");
  chk_unmapped: assert property (s_rd(8'h16) |=> o_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule

bind cgcr_regs cgcr_regs_checker cgcr_regs_checker_inst (.*);

// [testbench/cgcr_ee_model.sv]
`timescale 1ns/10ps
// ****
// Serial EEPROM: 3 opcode and 6 address bits in, 16 bits out
// ****
module cgcr_ee_model #(
  parameter logic [15:0] W1 = 16'h1a2b, // Arbitrary word 1
  parameter logic [15:0] W2 = 16'h3c4d, // Arbitrary word 2
  parameter logic [15:0] W3 = 16'h5e6f  // Arbitrary word 3
) (
  input  wire logic i_cs, // Chip select
  input  wire logic i_sk, // Serial clock
  input  wire logic i_di, // Data from device
  output logic      o_do, // Data to device
  output logic      o_oe  // Model drives line
);
  logic [8:0]  cmd_r;
  logic [15:0] w;
  int          n_r;
  initial begin
    o_oe = 1'b0;
    o_do = 1'b1;
    n_r = 0;
    cmd_r = 9'h000;
  end
  // Data follows each rising clock; line released outside the word
  always @(posedge i_sk or negedge i_cs) begin
    if (!i_cs) begin
      n_r = 0;
      o_oe = 1'b0;
    end else begin
      if (n_r < 9) cmd_r = {cmd_r[7:0], i_di};
      w = cmd_r[5:0] == 6'h01 ? W1 : cmd_r[5:0] == 6'h02 ? W2 : W3;
      o_oe = n_r >= 8 && n_r < 24 && cmd_r[8:6] == 3'b110;
      if (o_oe) o_do = w[23 - n_r];
      n_r = n_r + 1;
    end
  end
endmodule

// [testbench/tb_top.sv]
`timescale 1ns/10ps
`include "cgcr_defines.vh"
// ****
// Register bank bench
// ****
module tb_top;
  localparam int LOAD_CYC = 5000; // Three 25-bit frames, 50 cycles a bit
  logic        i_core_clk = 1'b0;
  logic        i_reset, i_wr, i_rd, o_ee_dout, o_ee_doe, o_ee_sk, o_ee_cs;
  logic [7:0]  i_addr;
  logic [15:0] i_wdata, o_rdata, o_mac_low, o_mac_mid, o_mac_high, v, r;
  logic        i_tx_bist_done, i_tx_bist_fail, i_rx_bist_done;
  logic        i_rx_bist_fail, o_bist_start, o_drive_16ma, o_clk_src_sel;
  logic [2:0]  i_tx_bist_cnt, i_rx_bist_cnt;
  logic [1:0]  o_clk_div;
  logic        o_qm_reset, o_global_reset, m_do, m_oe;
  wire         i_ee_din;
  int          mismatches = 0;
  int          check_count = 0;
  cgcr_regs cgcr_regs_inst (.*);
  cgcr_ee_model cgcr_ee_model_inst (.i_cs(o_ee_cs), .i_sk(o_ee_sk),
    .i_di(i_ee_din), .o_do(m_do), .o_oe(m_oe));
  // Pulled-up data line, so the strap reads "fitted"
  assign i_ee_din = o_ee_doe ? o_ee_dout : (m_oe ? m_do : 1'b1);
  always #20 i_core_clk = ~i_core_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One-cycle strobes launched at the falling edge
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    @(negedge i_core_clk);
    {i_wr, i_addr, i_wdata} = {1'b1, a, d};
    @(negedge i_core_clk);
    i_wr = 1'b0;
  endtask
  task automatic rd16(input logic [7:0] a, output logic [15:0] d);
    @(negedge i_core_clk);
    {i_rd, i_addr} = {1'b1, a};
    @(negedge i_core_clk);
    i_rd = 1'b0;
    d = o_rdata;
  endtask
  // Wait out a full load, then compare all three words
  task automatic load_check();
    repeat (LOAD_CYC) @(negedge i_core_clk);
    chk(o_mac_low, 16'h1a2b);
    chk(o_mac_high, 16'h5e6f);
    rd16(`CGCR_OFF_MAC_MID, v);
    chk(v, 16'h3c4d);
    $display("eeprom load test done");
  endtask
  function automatic logic [15:0] ee_exp(input logic [15:0] w);
    return {10'h000, 1'b0, w[4], w[5] ? w[2] : 1'b1, w[2:0]};
  endfunction
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hang guard, two loads plus traffic
  initial begin
    #(40 * 20000);
    mismatches++;
    $display("Error %0t: watchdog expired", $time);
    print_verdict();
  end
  initial begin
    {i_reset, i_wr, i_rd, i_addr, i_wdata} = {1'b1, 26'h0};
    {i_tx_bist_done, i_tx_bist_fail, i_tx_bist_cnt} = 5'h00;
    {i_rx_bist_done, i_rx_bist_fail, i_rx_bist_cnt} = 5'h00;
    void'($urandom(73));
    repeat (4) @(negedge i_core_clk);
    i_reset = 1'b0;
    rd16(`CGCR_OFF_BUS_CLK, v);
    chk(v, `CGCR_RST_BUS_CLK);
    load_check();
    for (int k = 0; k < 8; k++) begin
      r = 16'($urandom);
      wr16(`CGCR_OFF_MAC_MID, r);
      wr16(`CGCR_OFF_MAC_HIGH, ~r);
      rd16(`CGCR_OFF_MAC_MID, v);
      chk(v, r);
      chk(o_mac_high, ~r);
    end
    for (int k = 0; k < 3; k++) begin
      wr16(`CGCR_OFF_BUS_CLK, {$urandom} & 16'hfffc | k);
      rd16(`CGCR_OFF_BUS_CLK, v);
      chk(v, i_wdata & 16'hfffb);
      chk({o_drive_16ma, o_clk_div}, {i_wdata[6], i_wdata[1:0]});
    end
    $display("bus clock test done");
    for (int k = 0; k < 4; k++) begin
      wr16(`CGCR_OFF_EE_PIN, {10'h000, k[0], 1'b1, 1'b0, 3'($urandom)});
      rd16(`CGCR_OFF_EE_PIN, v);
      chk(v, ee_exp(i_wdata));
      chk({o_ee_doe, o_ee_dout, o_ee_sk, o_ee_cs},
        {i_wdata[5], i_wdata[2:0]});
    end
    wr16(`CGCR_OFF_EE_PIN, 16'h0007);
    rd16(`CGCR_OFF_EE_PIN, v);
    chk(o_ee_cs, 1'b0);
    $display("eeprom pin test done");
    for (int k = 0; k < 4; k++) begin
      {i_tx_bist_done, i_tx_bist_fail, i_tx_bist_cnt} = 5'($urandom);
      {i_rx_bist_done, i_rx_bist_fail, i_rx_bist_cnt} = 5'($urandom);
      rd16(`CGCR_OFF_SELFTEST, v);
      chk(v, {3'h0, i_tx_bist_done, i_tx_bist_fail, i_tx_bist_cnt, 3'h0,
        i_rx_bist_done, i_rx_bist_fail, i_rx_bist_cnt});
    end
    wr16(8'h16, 16'hffff);
    rd16(8'h16, v);
    chk(v, 16'h0000);
    wr16(`CGCR_OFF_BUS_CLK, 16'h0041);
    wr16(`CGCR_OFF_SOFT_RST, 16'h0002);
    rd16(`CGCR_OFF_SOFT_RST, v);
    chk({v[1:0], o_qm_reset}, 3'b101);
    wr16(`CGCR_OFF_SOFT_RST, 16'h0001);
    rd16(`CGCR_OFF_SOFT_RST, v);
    chk({o_global_reset, o_drive_16ma, o_qm_reset}, 3'b100);
    wr16(`CGCR_OFF_SOFT_RST, 16'h0000);
    load_check();
    rd16(`CGCR_OFF_BUS_CLK, v);
    chk(v, 16'h0000);
    $display("soft reset test done");
    print_verdict();
  end
endmodule
